// file: sbd_pkg.sv
// Shared constants, types and helpers of the secure bitstream decrypt gate
package sbd_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [11:0] CTRL_OFFS = 12'h000;
    localparam logic [11:0] STATUS_OFFS = 12'h004;
    localparam logic [11:0] FRAMES_OFFS = 12'h008;
    localparam logic [11:0] KEYINFO_OFFS = 12'h00c;

    // Field positions
    localparam int CTRL_LOAD_EN_BIT = 0;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_ERR_BIT = 1;
    localparam int ST_ACTIVE_BIT = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] ST_W1C_MASK = 32'h0000_0003;

    // ****************************************
    // Key and bitstream constants
    // ****************************************
    localparam int KEY_BITS = 256;
    localparam int KEY_WORDS = 8;
    localparam logic [31:0] SCRAMBLE_MASK = 32'h5a3c_96e1;
    localparam int SCRAMBLE_ROT = 7;
    localparam logic [7:0] HDR_ENCRYPTED = 8'ha5;
    localparam logic [7:0] HDR_PLAIN = 8'h5a;
    localparam logic [1:0] BYTE_SLOW_LAST = 2'h3;
    localparam logic [2:0] SERIAL_LAST = 3'h7;

    // Load modes at the mode pins
    typedef enum logic [2:0] {
        MODE_BYTE = 3'h0,
        MODE_SERIAL = 3'h1,
        MODE_FLASH = 3'h2,
        MODE_FLASH_RU = 3'h3,
        MODE_JTAG = 3'h4
    } sbd_mode_t;

    // Policy levels handed to the link side
    typedef struct packed {
        logic load_en;
        logic allow_enc;
        logic allow_plain;
        logic key_rdy;
    } sbd_policy_t;

    // Key programming request from the JTAG controller
    typedef struct packed {
        logic wr;
        logic erase;
        logic to_nv;
        logic set_tamper;
        logic [2:0] idx;
        logic [31:0] data;
    } sbd_keyreq_t;

    // Scramble before storage
    function automatic logic [31:0] sbd_scramble(input logic [31:0] w);
        logic [31:0] r;
        r = {w[31-SCRAMBLE_ROT:0], w[31:32-SCRAMBLE_ROT]};
        return r ^ SCRAMBLE_MASK;
    endfunction : sbd_scramble

    // Inverse transform for use
    function automatic logic [31:0] sbd_unscramble(input logic [31:0] w);
        logic [31:0] r;
        r = w ^ SCRAMBLE_MASK;
        return {r[SCRAMBLE_ROT-1:0], r[31:SCRAMBLE_ROT]};
    endfunction : sbd_unscramble

endpackage : sbd_pkg

// file: sbd_sync.sv
// Two flip-flop level synchroniser
module sbd_sync
    import sbd_pkg::*;
#(
    parameter int W = 1
) (
    // Destination clock
    input wire logic clock,
    input wire logic arst_n,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule : sbd_sync

// file: sbd_cipher.sv
// Decryption datapath stage, fixed one-cycle latency
module sbd_cipher
    import sbd_pkg::*;
#(
    parameter int KB = KEY_BITS
) (
    // Link clock
    input wire logic clock,
    input wire logic arst_n,
    // Control
    input wire logic restart,
    input wire logic decrypt,
    input wire logic [KB-1:0] key,
    // Byte stream
    input wire logic [7:0] in_byte,
    input wire logic in_valid,
    output logic [7:0] out_byte,
    output logic out_valid
);

    logic [4:0] pos_q;
    logic [7:0] ks;

    // Keystream byte from key position; cipher core slots in here
    always_comb begin
        ks = key[pos_q*8 +: 8] ^ {3'h0, pos_q};
    end

    // Same latency whether or not decrypting
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pos_q <= '0;
            out_byte <= '0;
            out_valid <= 1'b0;
        end else begin
            out_valid <= in_valid;
            if (restart) begin
                pos_q <= '0;
            end else if (in_valid) begin
                out_byte <= decrypt ? (in_byte ^ ks) : in_byte;
                pos_q <= pos_q + 5'h01;
            end
        end
    end

endmodule : sbd_cipher

// file: sbd_gate.sv
// Secure configuration front end: key store, load policy and decryption gate
module sbd_gate
    import sbd_pkg::*;
(
    // System clock and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // JTAG key programming port
    input wire sbd_keyreq_t jtag_key,
    // Pins
    input wire logic key_battery_ok,
    input wire logic [2:0] load_mode,
    // Link from the configuration source
    input wire logic config_data_clock,
    input wire logic config_frame,
    input wire logic [7:0] config_data,
    // Toward decompression
    output logic [7:0] cfg_out_data,
    output logic cfg_out_valid,
    output logic cfg_error
);

    // ****************************************
    // System domain: key storage
    // ****************************************

    logic [31:0] vol_key_q [KEY_WORDS];
    logic [31:0] nv_key_q [KEY_WORDS];
    logic vol_set_q;
    logic nv_set_q;
    logic tamper_q;
    logic batt_ok;
    logic frame_busy;
    logic [KEY_BITS-1:0] work_key;

    sbd_sync #(.W(1)) u_batt_sync (
        .clock(clock),
        .arst_n(arst_n),
        .d(key_battery_ok),
        .q(batt_ok)
    );

    // Volatile key: rewritable, erasable, lost without battery
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            vol_set_q <= 1'b0;
            for (int i = 0; i < KEY_WORDS; i++) begin
                vol_key_q[i] <= '0;
            end
        end else if (clk_en) begin
            if (!batt_ok || (jtag_key.erase && !frame_busy)) begin
                vol_set_q <= 1'b0;
                for (int i = 0; i < KEY_WORDS; i++) begin
                    vol_key_q[i] <= '0;
                end
            end else if (jtag_key.wr && !jtag_key.to_nv && !frame_busy) begin
                vol_key_q[jtag_key.idx] <= sbd_scramble(jtag_key.data);
                vol_set_q <= 1'b1;
            end
        end
    end

    // Non-volatile key: one programming pass, then locked
    logic nv_lock_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            nv_set_q <= 1'b0;
            nv_lock_q <= 1'b0;
            tamper_q <= 1'b0;
            for (int i = 0; i < KEY_WORDS; i++) begin
                nv_key_q[i] <= '0;
            end
        end else if (clk_en) begin
            if (jtag_key.wr && jtag_key.to_nv && !nv_lock_q && !frame_busy) begin
                nv_key_q[jtag_key.idx] <= sbd_scramble(jtag_key.data);
                nv_set_q <= 1'b1;
                nv_lock_q <= (jtag_key.idx == 3'(KEY_WORDS - 1));
            end
            if (jtag_key.set_tamper && nv_lock_q) begin
                tamper_q <= 1'b1;
            end
        end
    end

    // Unscrambled working key, non-volatile preferred; internal only
    always_comb begin
        for (int i = 0; i < KEY_WORDS; i++) begin
            work_key[i*32 +: 32] = nv_lock_q ? sbd_unscramble(nv_key_q[i])
                                             : sbd_unscramble(vol_key_q[i]);
        end
    end

    // ****************************************
    // System domain: policy
    // ****************************************

    logic [31:0] ctrl_q;
    sbd_policy_t pol;
    logic key_present;

    assign key_present = nv_lock_q || vol_set_q;

    // Which bitstreams may load now
    always_comb begin
        pol.load_en = ctrl_q[CTRL_LOAD_EN_BIT];
        pol.allow_enc = key_present;
        pol.allow_plain = !tamper_q;
        pol.key_rdy = key_present && !jtag_key.wr && !jtag_key.erase;
    end

    // ****************************************
    // Link domain: capture and gate
    // ****************************************

    typedef enum {L_IDLE, L_HEAD, L_DATA, L_ERR} sbd_lstate_t;

    sbd_lstate_t lst_q;
    sbd_policy_t pol_l;
    logic [2:0] mode_l;
    logic [KEY_BITS-1:0] lkey_q;
    logic enc_q;
    logic [7:0] shift_q;
    logic [2:0] bit_q;
    logic [1:0] phase_q;
    logic [7:0] cap_byte;
    logic cap_valid;
    logic slow;
    logic head_ok_enc;
    logic head_ok_plain;
    logic done_tgl_q;
    logic err_tgl_q;
    logic act_q;

    sbd_sync #(.W($bits(sbd_policy_t))) u_pol_sync (
        .clock(config_data_clock),
        .arst_n(arst_n),
        .d(pol),
        .q(pol_l)
    );

    sbd_sync #(.W(3)) u_mode_sync (
        .clock(config_data_clock),
        .arst_n(arst_n),
        .d(load_mode),
        .q(mode_l)
    );

    // Byte mode with decryption takes one byte per four clocks
    assign slow = enc_q && (lst_q == L_DATA) && (mode_l == MODE_BYTE);

    // Bit or byte assembly; serial timing unchanged by decryption
    always_ff @(posedge config_data_clock or negedge arst_n) begin
        if (!arst_n) begin
            shift_q <= '0;
            bit_q <= '0;
            phase_q <= '0;
        end else if (!config_frame) begin
            bit_q <= '0;
            phase_q <= '0;
        end else begin
            shift_q <= {shift_q[6:0], config_data[0]};
            bit_q <= bit_q + 3'h1;
            phase_q <= slow ? phase_q + 2'h1 : 2'h0;
        end
    end

    // Byte ready this cycle
    always_comb begin
        cap_byte = config_data;
        cap_valid = 1'b0;
        if (config_frame) begin
            if (mode_l == MODE_BYTE) begin
                cap_valid = !slow || (phase_q == BYTE_SLOW_LAST);
            end else begin
                cap_byte = {shift_q[6:0], config_data[0]};
                cap_valid = (bit_q == SERIAL_LAST);
            end
        end
    end

    // Header check against the policy
    assign head_ok_enc = (cap_byte == HDR_ENCRYPTED) && pol_l.allow_enc && pol_l.key_rdy
                         && (mode_l != MODE_JTAG);
    assign head_ok_plain = (cap_byte == HDR_PLAIN) && pol_l.allow_plain;

    // Key copy: frame_busy holds off JTAG key writes and erase while a frame runs; battery loss still clears the volatile key
    logic [KEY_BITS-1:0] work_key_l;
    assign work_key_l = work_key;

    // Frame state machine
    always_ff @(posedge config_data_clock or negedge arst_n) begin
        if (!arst_n) begin
            lst_q <= L_IDLE;
            enc_q <= 1'b0;
            lkey_q <= '0;
            done_tgl_q <= 1'b0;
            err_tgl_q <= 1'b0;
            act_q <= 1'b0;
        end else begin
            case (lst_q)
                L_IDLE: begin
                    if (config_frame && pol_l.load_en) begin
                        lst_q <= L_HEAD;
                        act_q <= 1'b1;
                    end
                end
                L_HEAD: begin
                    if (!config_frame) begin
                        lst_q <= L_IDLE;
                        act_q <= 1'b0;
                    end else if (cap_valid) begin
                        if (head_ok_enc || head_ok_plain) begin
                            lst_q <= L_DATA;
                            enc_q <= head_ok_enc;
                            lkey_q <= work_key_l;
                        end else begin
                            lst_q <= L_ERR;
                            err_tgl_q <= !err_tgl_q;
                        end
                    end
                end
                L_DATA: begin
                    if (!config_frame) begin
                        lst_q <= L_IDLE;
                        act_q <= 1'b0;
                        done_tgl_q <= !done_tgl_q;
                    end
                end
                L_ERR: begin
                    if (!config_frame) begin
                        lst_q <= L_IDLE;
                        act_q <= 1'b0;
                    end
                end
                default: begin
                    lst_q <= L_IDLE;
                end
            endcase
        end
    end

    // Decrypt encrypted frames before their bytes leave toward decompression; plain frames pass unchanged
    sbd_cipher #(.KB(KEY_BITS)) u_cipher (
        .clock(config_data_clock),
        .arst_n(arst_n),
        .restart(lst_q != L_DATA),
        .decrypt(enc_q),
        .key(lkey_q),
        .in_byte(cap_byte),
        .in_valid(cap_valid && (lst_q == L_DATA)),
        .out_byte(cfg_out_data),
        .out_valid(cfg_out_valid)
    );

    // ****************************************
    // Back to the system domain
    // ****************************************

    logic [2:0] ev_s;
    logic done_seen_q;
    logic err_seen_q;
    logic done_ev;
    logic err_ev;

    sbd_sync #(.W(3)) u_ev_sync (
        .clock(clock),
        .arst_n(arst_n),
        .d({act_q, err_tgl_q, done_tgl_q}),
        .q(ev_s)
    );

    assign frame_busy = ev_s[2];
    assign done_ev = ev_s[0] != done_seen_q;
    assign err_ev = ev_s[1] != err_seen_q;

    // Toggle edge detection
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            done_seen_q <= 1'b0;
            err_seen_q <= 1'b0;
        end else if (clk_en) begin
            done_seen_q <= ev_s[0];
            err_seen_q <= ev_s[1];
        end
    end

    // ****************************************
    // APB slave
    // ****************************************

    logic [31:0] status_q;
    logic [15:0] frames_q;
    logic wr_acc;
    logic rd_acc;
    logic addr_hit;

    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite && clk_en;
    assign rd_acc = psel && penable && !pwrite && clk_en;
    assign addr_hit = (paddr == CTRL_OFFS) || (paddr == STATUS_OFFS)
                      || (paddr == FRAMES_OFFS) || (paddr == KEYINFO_OFFS);
    assign pslverr = psel && penable && !addr_hit;
    assign cfg_error = status_q[ST_ERR_BIT];

    // Control register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_acc && paddr == CTRL_OFFS) begin
            ctrl_q <= pwdata & CTRL_RESET;
        end
    end

    // Sticky status, set wins over write-one-clear
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= '0;
            frames_q <= '0;
        end else if (clk_en) begin
            if (wr_acc && paddr == STATUS_OFFS) begin
                status_q <= status_q & ~(pwdata & ST_W1C_MASK);
            end
            if (done_ev) begin
                status_q[ST_DONE_BIT] <= 1'b1;
                frames_q <= frames_q + 16'h0001;
            end
            if (err_ev) begin
                status_q[ST_ERR_BIT] <= 1'b1;
            end
        end
    end

    // Read data: control, status, frame count and key flags only, never key or configuration data
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite && clk_en) begin
            case (paddr)
                CTRL_OFFS: prdata <= ctrl_q;
                STATUS_OFFS: prdata <= {29'h0, frame_busy, status_q[1:0]};
                FRAMES_OFFS: prdata <= {16'h0, frames_q};
                KEYINFO_OFFS: prdata <= {28'h0, tamper_q, batt_ok, nv_lock_q, vol_set_q};
                default: prdata <= '0;
            endcase
        end
    end

endmodule : sbd_gate

// file: sbd_gate_monitor.sv
// Port checker for the secure bitstream decrypt gate
module sbd_gate_monitor
    import sbd_pkg::*;
(
    // System side
    input wire logic clock,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cfg_error,
    // Link side
    input wire logic config_data_clock,
    input wire logic config_frame,
    input wire logic [2:0] load_mode,
    input wire logic cfg_out_valid
);
    // Access phase and decode
    wire acc = psel && penable;
    wire mapped = paddr inside {CTRL_OFFS, STATUS_OFFS, FRAMES_OFFS, KEYINFO_OFFS};

    AST_PREADY: assert property (@(posedge clock) disable iff (!arst_n)
        acc |-> pready) else $error("access not answered");
    AST_UNMAP_ERR: assert property (@(posedge clock) disable iff (!arst_n)
        acc && !mapped |-> pslverr) else $error("unmapped access not refused");
    AST_MAP_OK: assert property (@(posedge clock) disable iff (!arst_n)
        acc && mapped |-> !pslverr) else $error("mapped access refused");
    AST_UNMAP_ZERO: assert property (@(posedge clock) disable iff (!arst_n)
        acc && !pwrite && !mapped |-> prdata == 32'h0) else $error("unmapped read not zero");
    AST_PRDATA_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
        !(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
    AST_ERR_STICKY: assert property (@(posedge clock) disable iff (!arst_n)
        cfg_error && !(acc && paddr == STATUS_OFFS) |=> cfg_error) else $error("error lost");
    AST_IDLE_QUIET: assert property (@(posedge config_data_clock) disable iff (!arst_n)
        !config_frame [*2] |-> !cfg_out_valid) else $error("output outside frame");
    AST_VALID_IN_FRAME: assert property (@(posedge config_data_clock) disable iff (!arst_n)
        cfg_out_valid |-> $past(config_frame)) else $error("output without capture");
    AST_SERIAL_GAP: assert property (@(posedge config_data_clock) disable iff (!arst_n)
        cfg_out_valid && load_mode != MODE_BYTE |=> !cfg_out_valid [*7])
        else $error("serial byte too early");

    // Main scenarios reached
    COV_SERIAL: cover property (@(posedge config_data_clock) cfg_out_valid && load_mode != MODE_BYTE);
    COV_ERR: cover property (@(posedge clock) $rose(cfg_error));
    COV_UNMAP: cover property (@(posedge clock) acc && !mapped);
endmodule : sbd_gate_monitor

bind sbd_gate sbd_gate_monitor u_mon (.clock(clock), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr),
    .cfg_error(cfg_error), .config_data_clock(config_data_clock),
    .config_frame(config_frame), .load_mode(load_mode), .cfg_out_valid(cfg_out_valid));

// file: sbd_host_model.sv
// Behavioural configuration source on the link side
module sbd_host_model
    import sbd_pkg::*;
(
    // Link toward the gate
    output logic config_data_clock,
    output logic config_frame,
    output logic [7:0] config_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // Bytes of the next frame
    logic [7:0] fq[$];

    // Clock stands high between frames
    initial begin
        config_data_clock = 1'b1;
        config_frame = 1'b0;
        config_data = 8'h00;
    end

    // One link period ending on a rising edge
    task automatic tick();
        #7.5 config_data_clock = 1'b0;
        #7.5 config_data_clock = 1'b1;
    endtask : tick

    // Frame low, released data keeps toggling
    task automatic idle(input int n);
        config_frame <= 1'b0;
        repeat (n) begin
            config_data <= ~config_data;
            tick();
        end
    endtask : idle

    // Send queued bytes, rep periods per byte in byte mode
    task automatic run(input logic ser, input int rep);
        logic [7:0] b;
        config_frame <= 1'b1;
        // Byte mode: header also stands on the frame's opening edge
        if (!ser) begin
            config_data <= fq[0];
            tick();
        end
        while (fq.size() > 0) begin
            b = fq.pop_front();
            if (ser) begin
                for (int i = 7; i >= 0; i--) begin
                    config_data <= {~config_data[7:1], b[i]};
                    tick();
                end
            end else begin
                config_data <= b;
                repeat (rep) tick();
            end
        end
        idle(3);
    endtask : run
endmodule : sbd_host_model

// file: sbd_gate_test.sv
// Self-checking bench for the secure bitstream decrypt gate
module sbd_gate_test
    import sbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NB = 3;
    // Power-up wait before key programming, scaled far down for the bench
    localparam int KEY_WAIT = 24;

    // Design signals
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    sbd_keyreq_t jtag_key = '0;
    logic key_battery_ok = 1'b1;
    logic [2:0] load_mode = MODE_SERIAL;
    logic config_data_clock;
    logic config_frame;
    logic [7:0] config_data;
    logic [7:0] cfg_out_data;
    logic cfg_out_valid;
    logic cfg_error;
    // Bench state
    logic [7:0] got[$];
    logic [31:0] rv;
    logic ev;
    int miscompares = 0;
    int num_checks = 0;
    sbd_mode_t mlist[4] = '{MODE_BYTE, MODE_SERIAL, MODE_FLASH, MODE_FLASH_RU};

    sbd_gate uut (.clock, .arst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .jtag_key, .key_battery_ok, .load_mode, .config_data_clock,
        .config_frame, .config_data, .cfg_out_data, .cfg_out_valid, .cfg_error);
    sbd_host_model host (.config_data_clock, .config_frame, .config_data);

    // System clock and output capture
    always #25 clock = ~clock;
    always @(posedge config_data_clock) if (cfg_out_valid === 1'b1) got.push_back(cfg_out_data);

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rv, exp);
    endtask : rd_chk

    // One-cycle request from the key programming port
    task automatic key_op(input sbd_keyreq_t k);
        @(posedge clock);
        jtag_key <= k;
        @(posedge clock);
        jtag_key <= '0;
    endtask : key_op

    task automatic keyload(input logic nv);
        for (int i = 0; i < KEY_WORDS; i++) key_op({2'b10, nv, 1'b0, 3'(i), {4{8'(i + 1)}}});
    endtask : keyload

    // Whole frame: header then NB payload bytes, then status check and clear
    task automatic frame(input sbd_mode_t m, input logic enc, input logic ok);
        got.delete();
        @(posedge clock);
        load_mode <= m;
        host.idle(3);
        host.fq.push_back(enc ? HDR_ENCRYPTED : HDR_PLAIN);
        for (int i = 0; i < NB; i++) host.fq.push_back(8'h31 + 8'(i));
        host.run(m != MODE_BYTE, (m == MODE_BYTE && enc) ? 4 : 1);
        repeat (10) @(posedge clock);
        check("byte count", 32'(got.size()), ok ? NB : 0);
        for (int i = 0; i < got.size(); i++) begin
            if (!enc) check("plain byte", {24'h0, got[i]}, 32'h31 + i);
        end
        check("error pin", {31'h0, cfg_error}, {31'h0, !ok});
        apb(1'b0, STATUS_OFFS, 32'h0);
        check("error flag", {31'h0, rv[ST_ERR_BIT]}, {31'h0, !ok});
        check("done flag", {31'h0, rv[ST_DONE_BIT]}, {31'h0, ok});
        apb(1'b1, STATUS_OFFS, ST_W1C_MASK);
    endtask : frame

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        fork
            host.idle(4);
            repeat (4) @(posedge clock);
        join
        @(posedge clock);
        arst_n <= 1'b1;
        host.idle(4);
        repeat (KEY_WAIT) @(posedge clock);
        rd_chk("ctrl reset", CTRL_OFFS, CTRL_RESET);
        rd_chk("status reset", STATUS_OFFS, 32'h0);
        rd_chk("keyinfo reset", KEYINFO_OFFS, 32'h4);
        for (int i = 4; i < 12; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check("hidden data", rv, 32'h0);
            check("hidden error", {31'h0, ev}, 32'h1);
        end
        $display("test reset done");
        frame(MODE_SERIAL, 1'b0, 1'b1);
        frame(MODE_BYTE, 1'b1, 1'b0);
        rd_chk("status cleared", STATUS_OFFS, 32'h0);
        $display("test no key done");
        keyload(1'b0);
        rd_chk("volatile set", KEYINFO_OFFS, 32'h5);
        foreach (mlist[i]) frame(mlist[i], 1'b1, 1'b1);
        frame(MODE_BYTE, 1'b0, 1'b1);
        frame(MODE_JTAG, 1'b1, 1'b0);
        $display("test volatile key done");
        @(posedge clock);
        key_battery_ok <= 1'b0;
        repeat (6) @(posedge clock);
        rd_chk("battery lost", KEYINFO_OFFS, 32'h0);
        key_battery_ok <= 1'b1;
        repeat (6) @(posedge clock);
        frame(MODE_SERIAL, 1'b1, 1'b0);
        $display("test battery done");
        keyload(1'b1);
        rd_chk("nv locked", KEYINFO_OFFS, 32'h6);
        key_op({4'b0100, 3'h0, 32'h0});
        rd_chk("nv kept", KEYINFO_OFFS, 32'h6);
        key_op({4'b0001, 3'h0, 32'h0});
        rd_chk("tamper set", KEYINFO_OFFS, 32'he);
        frame(MODE_FLASH, 1'b1, 1'b1);
        frame(MODE_SERIAL, 1'b0, 1'b0);
        frame(MODE_FLASH_RU, 1'b1, 1'b1);
        rd_chk("frame count", FRAMES_OFFS, 32'h8);
        $display("test tamper done");
        close_out();
    end

    // Watchdog well beyond the expected run
    initial begin
        #2000000;
        miscompares++;
        close_out();
    end
endmodule : sbd_gate_test
